// ===== hotplug_slot_status_control.sv
/*
  Hot-plug slot control (upper part) and slot status registers for
  one switch port, reached over classic Wishbone, 32-bit data.
  Assumes sensor pins are asynchronous, while link-active and
  command-done come from logic on clk_i.
*/
`timescale 1ns/10ps
// Summary of operation
// R1: Interlock toggle control bit 11 always reads as zero.
// R2: Writing one to bit 11 toggles a fitted interlock; zero does nothing.
// R3: Without interlock capability, bit 11 is read-only zero, no toggle.
// R4: Link-active-change enable bit 12 lets that event raise a hot-plug event.
// R5: Attention button press sets status bit 0; reset zero; write one clears.
// R6: Power fault report sets status bit 1; write one clears.
// R7: Retention latch sensor change sets status bit 2; write one clears.
// R8: Card presence change sets status bit 3; write one clears.
// R9: Completed issued command sets status bit 4; write one clears.
// R10: Status bit 5 shows latch state, 0 closed, 1 open.
// R11: Status bit 6 shows card presence, reset value one.
// R12: Status bit 7 shows interlock state when fitted, 1 engaged.
// R13: Link layer active change sets status bit 8; write one clears.
// R14: Hot-plug event only while master enable control bit 5 set.
// R15: Writing zero leaves flags; reserved bits ignore writes, read zero.
module hotplug_slot_status_control
  import hp_slot_pkg::*;
(
  input  wire logic        clk_i,            // Config clock, 25 MHz
  input  wire logic        rst_i,            // Sync reset, high
  input  wire logic        wb_cyc_i,         // Bus cycle
  input  wire logic        wb_stb_i,         // Strobe
  input  wire logic        wb_we_i,          // Write enable
  input  wire logic [11:0] wb_adr_i,         // Byte address
  input  wire logic [3:0]  wb_sel_i,         // Byte lanes
  input  wire logic [31:0] wb_dat_i,         // Write data
  output logic      [31:0] wb_dat_o,         // Read data
  output logic             wb_ack_o,         // Acknowledge
  input  wire logic        attn_button_i,    // Button pressed pin
  input  wire logic        power_fault_i,    // Power fault pin
  input  wire logic        latch_open_i,     // Latch open pin
  input  wire logic        card_present_i,   // Presence pin
  input  wire logic        interlock_on_i,   // Interlock engaged pin
  input  wire logic        link_layer_active_i, // Link active level
  input  wire logic        cmd_done_i,       // Command done pulse
  output logic             interlock_toggle_o, // Toggle pulse
  output logic             hotplug_event_o   // Hot-plug event level
);

  hp_sense_if sense_bus ();

  hp_in_sync #(
    .W       (SENSE_W),
    .RST_VAL (SENSE_RST)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i ({interlock_on_i, card_present_i, latch_open_i,
             power_fault_i, attn_button_i}),
    .sense (sense_bus.src)
  );

  // Lane that carries a given data bit
  function automatic logic lane(input logic [3:0]  sel,
                                input int unsigned pos);
    return sel[pos / 8];
  endfunction

  logic [SENSE_W-1:0]  lvl;
  logic [SENSE_W-1:0]  prev_q;
  logic                lal_q;
  logic [CTL_EN_W-1:0] ctl_en_q;
  logic                lac_en_q;
  logic                ilk_cap_q;
  logic [FLAG_W-1:0]   flags_q;
  logic [FLAG_W-1:0]   flags_d;
  logic                ack_q;
  logic [31:0]         dat_q;
  logic                tog_q;
  logic                irq_q;

  assign lvl = sense_bus.level;

  // Bus decode
  wire        req     = wb_cyc_i & wb_stb_i;
  wire [9:0]  idx     = wb_adr_i[11:2];
  wire        hit_ctl = idx == SLOT_CTL_IDX;
  wire        hit_sts = idx == SLOT_STS_IDX;
  wire        hit_cfg = idx == SLOT_CFG_IDX;
  // Write lands on the edge that samples ack
  wire        wr_go   = req & wb_we_i & ack_q;
  wire        wr_ctl  = wr_go & hit_ctl;
  wire        wr_sts  = wr_go & hit_sts;
  wire        wr_cfg  = wr_go & hit_cfg;

  // Sensor events
  wire attn_rise = lvl[SN_ATTN] & ~prev_q[SN_ATTN];
  wire pf_rise   = lvl[SN_PFAULT] & ~prev_q[SN_PFAULT];
  wire latch_chg = lvl[SN_LATCH] ^ prev_q[SN_LATCH];
  wire pres_chg  = lvl[SN_PRES] ^ prev_q[SN_PRES];
  wire lac_chg   = link_layer_active_i ^ lal_q;

  wire [FLAG_W-1:0] set_v = {lac_chg, cmd_done_i, pres_chg,
                             latch_chg, pf_rise, attn_rise};

  // Write one clears, per byte lane
  wire        clr_hi = wr_sts & lane(wb_sel_i, STS_LAC_BIT);
  wire        clr_lo = wr_sts & lane(wb_sel_i, STS_FLAG_LO);
  wire [FLAG_W-1:0] clr_v = {
    clr_hi & wb_dat_i[STS_LAC_BIT],
    {(FLAG_W-1){clr_lo}} & wb_dat_i[FLAG_W-2:0]
  };

  // Set wins over a clear in the same cycle
  assign flags_d = (flags_q & ~clr_v) | set_v; // R5 R6 R7 R8 R9 R13 R15

  wire toggle_d = wr_ctl & lane(wb_sel_i, CTL_ILK_BIT)
                & wb_dat_i[CTL_ILK_BIT] & ilk_cap_q; // R2 R3

  wire ilk_state = ilk_cap_q & lvl[SN_ILK]; // R12

  // Read views; unused and reserved bits are zero
  wire [15:0] ctl_rd = {3'h0, lac_en_q, 6'h00, ctl_en_q}; // R1 R15
  wire [15:0] sts_rd = {7'h00, flags_q[FLAG_W-1], ilk_state,
                        lvl[SN_PRES], lvl[SN_LATCH],
                        flags_q[FLAG_W-2:0]}; // R10 R11 R15
  wire [15:0] cfg_rd = {15'h0000, ilk_cap_q};

  wire [15:0] rd_word = hit_ctl ? ctl_rd :
                        hit_sts ? sts_rd :
                        hit_cfg ? cfg_rd : 16'h0000;

  wire [FLAG_W-1:0] en_v = {lac_en_q, ctl_en_q[FLAG_W-2:0]}; // R4
  wire irq_d = ctl_en_q[CTL_HOTPLUG_IRQ_MASTER_EN_BIT] & |(flags_q & en_v); // R14

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        dat_q <= {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_en_q <= CTL_EN_RST;
    end else if (wr_ctl & lane(wb_sel_i, 0)) begin
      ctl_en_q <= wb_dat_i[CTL_EN_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lac_en_q <= 1'b0;
    end else if (wr_ctl & lane(wb_sel_i, CTL_LAC_BIT)) begin
      lac_en_q <= wb_dat_i[CTL_LAC_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ilk_cap_q <= 1'b0;
    end else if (wr_cfg & lane(wb_sel_i, CFG_ILK_BIT)) begin
      ilk_cap_q <= wb_dat_i[CFG_ILK_BIT];
    end
  end

  // Previous levels start at reset values, so no event at release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q  <= SENSE_RST;
      lal_q   <= 1'b0;
      flags_q <= FLAG_RST;
      tog_q   <= 1'b0;
      irq_q   <= 1'b0;
    end else begin
      prev_q  <= lvl;
      lal_q   <= link_layer_active_i;
      flags_q <= flags_d;
      tog_q   <= toggle_d;
      irq_q   <= irq_d;
    end
  end

  assign wb_ack_o           = ack_q;
  assign wb_dat_o           = dat_q;
  assign interlock_toggle_o = tog_q;
  assign hotplug_event_o    = irq_q;

  wire rd_ack = wb_ack_o & ~wb_we_i;

  a_toggle_reads_zero: assert property ( // R1
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_ctl |-> !wb_dat_o[CTL_ILK_BIT])
    else $error("interlock toggle bit read as one");

  a_toggle_on_write: assert property ( // R2
    @(posedge clk_i) disable iff (rst_i)
    wr_ctl && wb_sel_i[1] && wb_dat_i[CTL_ILK_BIT] && ilk_cap_q
    |=> interlock_toggle_o ##1 !interlock_toggle_o)
    else $error("interlock toggle pulse missing or long");

  a_toggle_needs_cap: assert property ( // R3
    @(posedge clk_i) disable iff (rst_i)
    !ilk_cap_q || !wr_ctl |=> !interlock_toggle_o)
    else $error("interlock toggled without capability");

  a_link_event_out: assert property ( // R4
    @(posedge clk_i) disable iff (rst_i)
    ctl_en_q[CTL_HOTPLUG_IRQ_MASTER_EN_BIT] && lac_en_q && flags_q[FLAG_W-1]
    |=> hotplug_event_o)
    else $error("enabled link change gave no event");

  a_attn_flag_set: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    $rose(lvl[SN_ATTN]) |=> flags_q[0])
    else $error("button press not flagged");

  a_pfault_flag_set: assert property ( // R6
    @(posedge clk_i) disable iff (rst_i)
    $rose(lvl[SN_PFAULT]) |=> flags_q[1])
    else $error("power fault not flagged");

  a_latch_flag_set: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    lvl[SN_LATCH] != prev_q[SN_LATCH] |=> flags_q[2])
    else $error("latch change not flagged");

  a_pres_flag_set: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    $changed(lvl[SN_PRES]) |=> flags_q[3])
    else $error("presence change not flagged");

  a_cmd_flag_set: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    cmd_done_i |=> flags_q[4])
    else $error("command done not flagged");

  a_latch_read_back: assert property ( // R10
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_sts
    |-> wb_dat_o[STS_LATCH] == $past(lvl[SN_LATCH]))
    else $error("latch state read wrong");

  a_pres_read_back: assert property ( // R11
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_sts && $past(lvl[SN_PRES])
    |-> wb_dat_o[STS_PRES])
    else $error("presence state read wrong");

  a_ilk_read_back: assert property ( // R12
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_sts
    |-> wb_dat_o[STS_ILK] == $past(ilk_state))
    else $error("interlock state read wrong");

  a_link_flag_set: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    $changed(link_layer_active_i) |=> flags_q[FLAG_W-1])
    else $error("link active change not flagged");

  a_master_enable_gate: assert property ( // R14
    @(posedge clk_i) disable iff (rst_i)
    !ctl_en_q[CTL_HOTPLUG_IRQ_MASTER_EN_BIT] |=> !hotplug_event_o)
    else $error("event raised with master enable off");

  a_zero_write_keeps: assert property ( // R15
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && flags_q[0] && !wb_dat_i[0] |=> flags_q[0])
    else $error("zero write cleared a flag");

  a_reserved_read_zero: assert property ( // R15
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && (hit_sts || hit_ctl) |-> wb_dat_o[31:13] == 19'h0_0000)
    else $error("reserved bits read nonzero");

  // Clear side of each flag; a set in the same cycle wins instead
  a_attn_flag_clear: assert property ( // R5
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && wb_sel_i[0] && wb_dat_i[0] && !attn_rise |=> !flags_q[0])
    else $error("button flag not cleared by one");

  a_pfault_flag_clear: assert property ( // R6
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && wb_sel_i[0] && wb_dat_i[1] && !pf_rise |=> !flags_q[1])
    else $error("fault flag not cleared by one");

  a_latch_flag_clear: assert property ( // R7
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && wb_sel_i[0] && wb_dat_i[2] && !latch_chg |=> !flags_q[2])
    else $error("latch flag not cleared by one");

  a_pres_flag_clear: assert property ( // R8
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && wb_sel_i[0] && wb_dat_i[3] && !pres_chg |=> !flags_q[3])
    else $error("presence flag not cleared by one");

  a_cmd_flag_clear: assert property ( // R9
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && wb_sel_i[0] && wb_dat_i[4] && !cmd_done_i |=> !flags_q[4])
    else $error("command flag not cleared by one");

  a_link_flag_clear: assert property ( // R13
    @(posedge clk_i) disable iff (rst_i)
    wr_sts && wb_sel_i[1] && wb_dat_i[STS_LAC_BIT] && !lac_chg
    |=> !flags_q[FLAG_W-1])
    else $error("link change flag not cleared by one");

  // Reset values, seen at the first edge after release
  a_attn_reset_zero: assert property ( // R5
    @(posedge clk_i)
    $fell(rst_i) |-> !flags_q[0])
    else $error("button flag not zero after reset");

  a_pres_reset_one: assert property ( // R11
    @(posedge clk_i)
    $fell(rst_i) |-> lvl[SN_PRES])
    else $error("presence level not one after reset");

  a_link_en_read: assert property ( // R4
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_ctl
    |-> wb_dat_o[CTL_LAC_BIT] == $past(lac_en_q))
    else $error("link change enable read wrong");

  a_sts_reserved_zero: assert property ( // R15
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_sts
    |-> wb_dat_o[15:STS_LAC_BIT+1] == '0)
    else $error("reserved status bits read nonzero");

  a_toggle_single_pulse: assert property ( // R2
    @(posedge clk_i) disable iff (rst_i)
    interlock_toggle_o |=> !interlock_toggle_o)
    else $error("interlock toggle pulse too long");

  a_cap_hides_ilk: assert property ( // R12
    @(posedge clk_i) disable iff (rst_i)
    rd_ack && hit_sts && !$past(ilk_cap_q)
    |-> !wb_dat_o[STS_ILK])
    else $error("interlock state shown without capability");

endmodule

// ===== hotplug_slot_status_control_tb.sv
/*
  Bench for the slot register block: Wishbone master, random sensor
  traffic and an integer model. Assumes one clock; the master waits
  for ack however late it comes, the watchdog ends a hang.
*/
`timescale 1ns/10ps
module hotplug_slot_status_control_tb;
  import hp_slot_pkg::*;
  localparam logic [11:0] A_CTL = {SLOT_CTL_IDX, 2'b00};
  localparam logic [11:0] A_STS = {SLOT_STS_IDX, 2'b00};
  localparam logic [11:0] A_CFG = {SLOT_CFG_IDX, 2'b00};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [11:0] adr   = 12'h000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0000_0000;
  logic [3:0]  want  = 4'h8;
  logic        link  = 1'b0;
  logic        done  = 1'b0;
  logic [31:0] lfsr  = 32'h0000_ddbc;
  logic [31:0] rd, dat_o;
  logic        btn, pf, lat, card, ilk, tog, evt, ack;
  int          fail_count = 0;
  int          cmp_count  = 0;
  int          tog_seen   = 0;
  int          tog_exp    = 0;
  int          en, flg, ilk_m, cap;

  always #20 clk_i = ~clk_i;

  hotplug_slot_status_control uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .attn_button_i(btn),
    .power_fault_i(pf), .latch_open_i(lat), .card_present_i(card),
    .interlock_on_i(ilk), .link_layer_active_i(link),
    .cmd_done_i(done), .interlock_toggle_o(tog), .hotplug_event_o(evt));

  hp_slot_partner #(.ILK_DELAY(4)) far (
    .clk_i(clk_i), .rst_i(rst_i), .want_i(want), .toggle_i(tog),
    .attn_button_o(btn), .power_fault_o(pf), .latch_open_o(lat),
    .card_present_o(card), .interlock_on_o(ilk));

  // An unknown pulse counts as well, so it cannot hide
  always @(posedge clk_i) if (!rst_i && tog !== 1'b0) tog_seen++;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction

  function automatic logic [31:0] sts_m();
    return {23'h00_0000, flg[8], cap[0] & ilk_m[0], want[3], want[2],
            flg[4:0]};
  endfunction

  function automatic logic evt_m();
    return en[5] && (((flg & en & 31) != 0) || (flg[8] && en[12]));
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled, then releases
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    give_verdict();
  end

  initial begin
    {en, flg, ilk_m, cap} = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, A_STS, 32'h0000_0000);
    chk("sts reset", rd, 32'h0000_0040);
    wb(1'b1, A_CTL, 32'hffff_ffff);
    wb(1'b0, A_CTL, 32'h0000_0000);
    chk("ctl all ones", rd, 32'h0000_103f);
    wb(1'b1, 12'h3fc, 32'hffff_ffff);
    wb(1'b0, 12'h3fc, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    repeat (12) @(posedge clk_i);
    chk("no toggle", tog_seen, 32'h0000_0000);
    wb(1'b0, A_STS, 32'h0000_0000);
    chk("sts no ilk", rd, 32'h0000_0040);
    wb(1'b1, A_CFG, 32'h0000_0001);
    cap = 1;
    for (int i = 0; i < 60; i++) begin
      lfsr = nxt(lfsr);
      wb(1'b1, A_CTL, lfsr);
      en = int'(lfsr & 32'h0000_103f);
      if (lfsr[11]) begin
        tog_exp++;
        ilk_m ^= 1;
      end
      wb(1'b0, A_CTL, 32'h0000_0000);
      chk("ctl", rd, en);
      lfsr = nxt(lfsr);
      // Button and fault count on rising edges only
      if (lfsr[0] & ~want[0]) flg |= 1;
      if (lfsr[1] & ~want[1]) flg |= 2;
      if (lfsr[2] != want[2]) flg |= 4;
      if (lfsr[3] != want[3]) flg |= 8;
      if (lfsr[5]) flg |= 16;
      if (lfsr[4] != link) flg |= 256;
      want <= lfsr[3:0];
      link <= lfsr[4];
      done <= lfsr[5];
      @(posedge clk_i);
      done <= 1'b0;
      repeat (12) @(posedge clk_i);
      wb(1'b0, A_STS, 32'h0000_0000);
      chk("sts", rd, sts_m());
      chk("event", evt, evt_m());
      lfsr = nxt(lfsr);
      wb(1'b1, A_STS, lfsr);
      flg &= ~int'(lfsr & 32'h0000_011f);
      repeat (2) @(posedge clk_i);
      chk("event cleared", evt, evt_m());
    end
    wb(1'b0, A_STS, 32'h0000_0000);
    chk("sts end", rd, sts_m());
    chk("toggles", tog_seen, tog_exp);
    give_verdict();
  end
endmodule

// ===== hp_in_sync.sv
/*
  Three-stage synchroniser for the slot sensor pins. A new level is
  accepted once the second and third stages agree.
  Assumes pins are asynchronous to clk_i; clk_i is the config clock.
*/
`timescale 1ns/10ps
module hp_in_sync
  import hp_slot_pkg::*;
#(
  parameter int unsigned       W       = SENSE_W,
  parameter logic [W-1:0]      RST_VAL = SENSE_RST
) (
  input  wire logic         clk_i,  // Config clock
  input  wire logic         rst_i,  // Sync reset, high
  input  wire logic [W-1:0] pin_i,  // Raw sensor pins
  hp_sense_if.src           sense   // Filtered levels
);

  if (W != SENSE_W) begin : g_bad_width
    $error("hp_in_sync: W must equal SENSE_W");
  end

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] st_q;
  logic [W-1:0] st_d;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  // First stage feeds only the second
  assign st_d = (agree & s3_q) | (~agree & st_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      st_q <= RST_VAL;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  assign sense.level = st_q;

endmodule

// ===== hp_sense_if.sv
/*
  Carries the filtered slot sensor levels from the input
  synchroniser to the register block. Assumes one clock domain.
*/
`timescale 1ns/10ps
interface hp_sense_if;
  import hp_slot_pkg::*;

  logic [SENSE_W-1:0] level;

  modport src (output level);
  modport dst (input  level);
endinterface

// ===== hp_slot_partner.sv
/*
  Far-side slot model: sensor pins and a slow interlock mechanism.
  Assumes one clock; the bench chooses the wanted sensor levels.
*/
`timescale 1ns/10ps
module hp_slot_partner #(
  parameter int unsigned ILK_DELAY = 4
) (
  input  wire logic       clk_i,          // Config clock
  input  wire logic       rst_i,          // Sync reset, high
  input  wire logic [3:0] want_i,         // Card, latch, fault, button
  input  wire logic       toggle_i,       // Interlock toggle pulse
  output logic            attn_button_o,  // Button pin
  output logic            power_fault_o,  // Fault pin
  output logic            latch_open_o,   // Latch pin
  output logic            card_present_o, // Presence pin
  output logic            interlock_on_o  // Interlock pin
);
  logic [7:0] wait_q;
  logic       ilk_q;

  assign {card_present_o, latch_open_o, power_fault_o, attn_button_o} = want_i;
  assign interlock_on_o = ilk_q;

  // Mechanism is slow: it moves a few cycles after the pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 8'h00;
      ilk_q  <= 1'b0;
    end else if (toggle_i) begin
      wait_q <= ILK_DELAY[7:0];
    end else if (wait_q == 8'h01) begin
      wait_q <= 8'h00;
      ilk_q  <= ~ilk_q;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
    end
  end
endmodule

// ===== hp_slot_pkg.sv
/*
  Constants shared by the hot-plug slot register block: register
  indices, field positions, reset values and sensor bit order.
  Assumes a 32-bit classic Wishbone bus whose byte address is four
  times the register index.
*/
package hp_slot_pkg;

  // Register indices; byte address is index * 4
  localparam logic [9:0] SLOT_CTL_IDX = 10'h058;
  localparam logic [9:0] SLOT_STS_IDX = 10'h05a;
  localparam logic [9:0] SLOT_CFG_IDX = 10'h080;

  // Slot control fields
  localparam int unsigned CTL_EN_W     = 6;
  localparam int unsigned CTL_HOTPLUG_IRQ_MASTER_EN_BIT = 5;
  localparam int unsigned CTL_ILK_BIT  = 11;
  localparam int unsigned CTL_LAC_BIT  = 12;
  localparam logic [CTL_EN_W-1:0] CTL_EN_RST = 6'h00;

  // Slot status fields
  localparam int unsigned STS_FLAG_LO  = 0;
  localparam int unsigned STS_LATCH    = 5;
  localparam int unsigned STS_PRES     = 6;
  localparam int unsigned STS_ILK      = 7;
  localparam int unsigned STS_LAC_BIT  = 8;
  localparam int unsigned FLAG_W       = 6;
  localparam logic [FLAG_W-1:0] FLAG_RST = 6'h00;

  // Configuration field: interlock fitted
  localparam int unsigned CFG_ILK_BIT  = 0;

  // Sensor vector order after synchronisation
  localparam int unsigned SENSE_W      = 5;
  localparam int unsigned SN_ATTN      = 0;
  localparam int unsigned SN_PFAULT    = 1;
  localparam int unsigned SN_LATCH     = 2;
  localparam int unsigned SN_PRES      = 3;
  localparam int unsigned SN_ILK       = 4;
  // Card present out of reset, all else low
  localparam logic [SENSE_W-1:0] SENSE_RST = 5'h08;

endpackage
